/* core/dsnx_pkg.sv */
// shared constants and types of the debug sequencer next-state block
// assumes a classic wishbone master with 32-bit data and byte addresses
package dsnx_pkg;
	localparam int DSNX_ADR_W = 8;
	localparam int DSNX_DAT_W = 32;
	localparam int DSNX_SEL_W = 4;
	localparam int DSNX_CH_N = 4;
	// register indices, byte address is four times the index
	localparam logic [5:0] DSNX_IDX_CTL = 6'h26;
	localparam logic [5:0] DSNX_IDX_SCR = 6'h27;
	// debug_control_one fields
	localparam int DSNX_CTL_ARM_BIT = 7;
	localparam int DSNX_CTL_VIEW_LSB = 0;
	localparam logic [7:0] DSNX_CTL_RESET = 8'h00;
	localparam logic [7:0] DSNX_CTL_MASK = 8'h83;
	// state select registers: next_state_select in bits 3..0
	localparam logic [7:0] DSNX_SCR_RESET = 8'h00;
	localparam logic [7:0] DSNX_SCR_MASK = 8'h0F;
	// register_view_select codes
	localparam logic [1:0] DSNX_VIEW_S1 = 2'h0;
	localparam logic [1:0] DSNX_VIEW_S2 = 2'h1;
	localparam logic [1:0] DSNX_VIEW_S3 = 2'h2;
	localparam logic [1:0] DSNX_VIEW_FLAGS = 2'h3;
	// next_state_select codes
	localparam logic [3:0] DSNX_SC_0 = 4'h0;
	localparam logic [3:0] DSNX_SC_1 = 4'h1;
	localparam logic [3:0] DSNX_SC_2 = 4'h2;
	localparam logic [3:0] DSNX_SC_3 = 4'h3;
	localparam logic [3:0] DSNX_SC_4 = 4'h4;
	localparam logic [3:0] DSNX_SC_5 = 4'h5;
	localparam logic [3:0] DSNX_SC_6 = 4'h6;
	localparam logic [3:0] DSNX_SC_7 = 4'h7;
	localparam logic [3:0] DSNX_SC_8 = 4'h8;
	localparam logic [3:0] DSNX_SC_9 = 4'h9;
	localparam logic [3:0] DSNX_SC_A = 4'hA;
	localparam logic [3:0] DSNX_SC_B = 4'hB;
	localparam logic [3:0] DSNX_SC_C = 4'hC;
	localparam logic [3:0] DSNX_SC_D = 4'hD;
	// seq_idle doubles as "no transition" inside the selection logic
	typedef enum logic [2:0] {
		SEQ_IDLE,
		SEQ_STATE1,
		SEQ_STATE2,
		SEQ_STATE3,
		SEQ_FINAL
	} dsnx_seq_state_t;
	typedef struct packed {
		logic cyc;
		logic stb;
		logic we;
		logic [DSNX_ADR_W-1:0] adr;
		logic [DSNX_SEL_W-1:0] sel;
		logic [DSNX_DAT_W-1:0] dat;
	} dsnx_wb_req_t;
	typedef struct packed {
		logic ack;
		logic [DSNX_DAT_W-1:0] dat;
	} dsnx_wb_rsp_t;
endpackage

/* core/dsnx_sequencer.sv */
// debug trigger state sequencer with next-state selection for state1 and state2
// assumes match inputs come already qualified by comparator enables, on the same clock
`timescale 1ns/10ps
// What this block does
// [RULE_01] state1 code 1000: ch0 to s2, ch2 s3
// [RULE_02] state1 code 1010: ch1 to s2, ch3 s3
// [RULE_03] state1 code 1100: ch0..2 to s2
// [RULE_04] code 0111: ch1 to s3, ch0 final
// [RULE_05] code 1001: ch2 to s3, ch0 final
// [RULE_06] code 1011: ch3 to s3, ch1 final
// [RULE_07] reserved codes never cause a transition
// [RULE_08] state2 codes 0..2: any match to s1/s3/final
// [RULE_09] state2 codes 3..5: only ch3 to s1/s3/final
// [RULE_10] state2 code 0110: ch0 s1, ch1 s3
// [RULE_11] state2 code 1000: ch0 s1, ch2 s3
// [RULE_12] state2 code 1010: ch1 s1, ch3 s3
// [RULE_13] state2 code 1100: ch2 s1, ch3 final
// [RULE_14] state2 code 1101: ch0,1,3 to final
// [RULE_15] simultaneous matches: lowest channel wins
// [RULE_16] a final-state target beats all others
// [RULE_17] state2 register at index 0x27 when view 01
// [RULE_18] state2 register writable only when view 01, unarmed
// [RULE_19] bits 3..0 hold state2 select code
// [RULE_20] software enables comparators for their match channels
// [RULE_21] view 00/01/10 select registers, 11 match flags
// [RULE_22] state1 codes 0..2: any match to s2/s3/final
// [RULE_23] new state registered next edge, one per cycle
module dsnx_sequencer (
	input wire logic core_clk_in,
	input wire logic sys_rst_in,
	input wire dsnx_pkg::dsnx_wb_req_t wb_req_in,
	output dsnx_pkg::dsnx_wb_rsp_t wb_rsp_out,
	input wire logic [dsnx_pkg::DSNX_CH_N-1:0] match_in,
	output dsnx_pkg::dsnx_seq_state_t seq_state_out,
	output logic armed_out,
	output logic [dsnx_pkg::DSNX_CH_N-1:0] match_flags_out
);
	import dsnx_pkg::*;

	dsnx_wb_rsp_t rsp_reg;
	dsnx_seq_state_t state_reg;
	dsnx_seq_state_t state_next;
	logic [7:0] ctl_reg;
	logic [7:0] scr1_reg;
	logic [7:0] scr2_reg;
	logic [7:0] scr3_reg;
	logic [DSNX_CH_N-1:0] flags_reg;
	logic armed_reg;
	logic wr_take;
	logic ctl_wr;
	logic scr_wr;
	logic arm_evt;
	logic disarm_evt;
	logic [1:0] view;
	logic [7:0] rd_mux;

	function automatic logic reg_hit(input logic [DSNX_ADR_W-1:0] adr, input logic [5:0] idx);
		reg_hit = (adr[DSNX_ADR_W-1:2] == idx) && (adr[1:0] == 2'h0);
	endfunction

	// target of one matching channel; back is state2 seen from state1 and state1 from state2
	function automatic dsnx_seq_state_t chan_target(input dsnx_seq_state_t cur, input logic [3:0] code,
			input int ch);
		dsnx_seq_state_t back;
		dsnx_seq_state_t t;
		int solo;
		back = (cur == SEQ_STATE1) ? SEQ_STATE2 : SEQ_STATE1;
		solo = (cur == SEQ_STATE1) ? 2 : 3;
		t = SEQ_IDLE;
		case (code)
			DSNX_SC_0: begin
				t = back; // see [RULE_22] see [RULE_08]
			end
			DSNX_SC_1: begin
				t = SEQ_STATE3; // see [RULE_22] see [RULE_08]
			end
			DSNX_SC_2: begin
				t = SEQ_FINAL; // see [RULE_22] see [RULE_08]
			end
			DSNX_SC_3: begin
				t = (ch == solo) ? back : SEQ_IDLE; // see [RULE_09]
			end
			DSNX_SC_4: begin
				t = (ch == solo) ? SEQ_STATE3 : SEQ_IDLE; // see [RULE_09]
			end
			DSNX_SC_5: begin
				t = (ch == solo) ? SEQ_FINAL : SEQ_IDLE; // see [RULE_09]
			end
			DSNX_SC_6: begin
				if (ch == 0) begin
					t = back; // see [RULE_10]
				end else if (ch == 1) begin
					t = SEQ_STATE3; // see [RULE_10]
				end
			end
			DSNX_SC_7: begin
				if (ch == 0) begin
					t = SEQ_FINAL; // see [RULE_04]
				end else if (ch == 1) begin
					t = SEQ_STATE3; // see [RULE_04]
				end
			end
			DSNX_SC_8: begin
				if (ch == 0) begin
					t = back; // see [RULE_01] see [RULE_11]
				end else if (ch == 2) begin
					t = SEQ_STATE3; // see [RULE_01] see [RULE_11]
				end
			end
			DSNX_SC_9: begin
				if (ch == 0) begin
					t = SEQ_FINAL; // see [RULE_05]
				end else if (ch == 2) begin
					t = SEQ_STATE3; // see [RULE_05]
				end
			end
			DSNX_SC_A: begin
				if (ch == 1) begin
					t = back; // see [RULE_02] see [RULE_12]
				end else if (ch == 3) begin
					t = SEQ_STATE3; // see [RULE_02] see [RULE_12]
				end
			end
			DSNX_SC_B: begin
				if (ch == 1) begin
					t = SEQ_FINAL; // see [RULE_06]
				end else if (ch == 3) begin
					t = SEQ_STATE3; // see [RULE_06]
				end
			end
			DSNX_SC_C: begin
				if (cur == SEQ_STATE1) begin
					t = (ch != 3) ? SEQ_STATE2 : SEQ_IDLE; // see [RULE_03]
				end else if (ch == 2) begin
					t = SEQ_STATE1; // see [RULE_13]
				end else if (ch == 3) begin
					t = SEQ_FINAL; // see [RULE_13]
				end
			end
			DSNX_SC_D: begin
				if (cur == SEQ_STATE2 && ch != 2) begin
					t = SEQ_FINAL; // see [RULE_14]
				end
			end
			default: begin
				t = SEQ_IDLE; // see [RULE_07]
			end
		endcase
		chan_target = t;
	endfunction

	// final wins outright, otherwise the lowest matching channel with a target
	function automatic dsnx_seq_state_t pick_next(input dsnx_seq_state_t cur, input logic [3:0] code,
			input logic [DSNX_CH_N-1:0] m);
		dsnx_seq_state_t best;
		dsnx_seq_state_t t;
		logic got_final;
		best = SEQ_IDLE;
		got_final = 1'b0;
		for (int ch = 0; ch < DSNX_CH_N; ch++) begin
			t = chan_target(cur, code, ch);
			if (m[ch] && t == SEQ_FINAL) begin
				got_final = 1'b1; // see [RULE_16]
			end else if (m[ch] && t != SEQ_IDLE && best == SEQ_IDLE) begin
				best = t; // see [RULE_15]
			end
		end
		pick_next = got_final ? SEQ_FINAL : best;
	endfunction

	assign view = ctl_reg[DSNX_CTL_VIEW_LSB +: 2];
	// a write lands at the edge where the master sees ack
	assign wr_take = wb_req_in.cyc && wb_req_in.stb && wb_req_in.we && rsp_reg.ack && wb_req_in.sel[0];
	assign ctl_wr = wr_take && reg_hit(wb_req_in.adr, DSNX_IDX_CTL);
	assign scr_wr = wr_take && reg_hit(wb_req_in.adr, DSNX_IDX_SCR) && !armed_reg; // see [RULE_18]
	assign arm_evt = ctl_wr && wb_req_in.dat[DSNX_CTL_ARM_BIT] && !armed_reg;
	assign disarm_evt = ctl_wr && !wb_req_in.dat[DSNX_CTL_ARM_BIT];

	always_comb begin
		rd_mux = 8'h00;
		if (reg_hit(wb_req_in.adr, DSNX_IDX_CTL)) begin
			rd_mux = {armed_reg, ctl_reg[6:0]};
		end else if (reg_hit(wb_req_in.adr, DSNX_IDX_SCR)) begin
			if (view == DSNX_VIEW_S1) begin
				rd_mux = scr1_reg; // see [RULE_21]
			end else if (view == DSNX_VIEW_S2) begin
				rd_mux = scr2_reg; // see [RULE_17] see [RULE_21]
			end else if (view == DSNX_VIEW_S3) begin
				rd_mux = scr3_reg; // see [RULE_21]
			end else begin
				rd_mux = {4'h0, flags_reg}; // see [RULE_21]
			end
		end
	end

	always_ff @(posedge core_clk_in) begin
		if (sys_rst_in) begin
			rsp_reg <= '0;
		end else begin
			rsp_reg.ack <= wb_req_in.cyc && wb_req_in.stb && !rsp_reg.ack;
			rsp_reg.dat <= {24'h000000, rd_mux};
		end
	end

	always_ff @(posedge core_clk_in) begin
		if (sys_rst_in) begin
			ctl_reg <= DSNX_CTL_RESET;
			armed_reg <= 1'b0;
		end else if (ctl_wr) begin
			ctl_reg <= wb_req_in.dat[7:0] & DSNX_CTL_MASK;
			armed_reg <= wb_req_in.dat[DSNX_CTL_ARM_BIT];
		end
	end

	always_ff @(posedge core_clk_in) begin
		if (sys_rst_in) begin
			scr1_reg <= DSNX_SCR_RESET;
			scr2_reg <= DSNX_SCR_RESET;
			scr3_reg <= DSNX_SCR_RESET;
		end else if (scr_wr) begin
			if (view == DSNX_VIEW_S1) begin
				scr1_reg <= wb_req_in.dat[7:0] & DSNX_SCR_MASK;
			end else if (view == DSNX_VIEW_S2) begin
				scr2_reg <= wb_req_in.dat[7:0] & DSNX_SCR_MASK; // see [RULE_18] see [RULE_19]
			end else if (view == DSNX_VIEW_S3) begin
				scr3_reg <= wb_req_in.dat[7:0] & DSNX_SCR_MASK;
			end
		end
	end

	// flags hold after the session and clear only on arming
	always_ff @(posedge core_clk_in) begin
		if (sys_rst_in) begin
			flags_reg <= '0;
		end else if (arm_evt) begin
			flags_reg <= '0;
		end else if (armed_reg) begin
			flags_reg <= flags_reg | match_in;
		end
	end

	always_comb begin
		state_next = SEQ_IDLE;
		if (state_reg == SEQ_STATE1) begin
			state_next = pick_next(SEQ_STATE1, scr1_reg[3:0], match_in);
		end else if (state_reg == SEQ_STATE2) begin
			state_next = pick_next(SEQ_STATE2, scr2_reg[3:0], match_in); // see [RULE_19]
		end
	end

	// state3 selection lies outside this block, so state3 holds
	always_ff @(posedge core_clk_in) begin
		if (sys_rst_in) begin
			state_reg <= SEQ_IDLE;
		end else if (arm_evt) begin
			state_reg <= SEQ_STATE1;
		end else if (disarm_evt) begin
			state_reg <= SEQ_IDLE;
		end else if (armed_reg && state_next != SEQ_IDLE) begin
			state_reg <= state_next; // see [RULE_23]
		end
	end

	assign wb_rsp_out = rsp_reg;
	assign seq_state_out = state_reg;
	assign armed_out = armed_reg;
	assign match_flags_out = flags_reg;

	default clocking cb @(posedge core_clk_in);
	endclocking
	default disable iff (sys_rst_in);

	// the sequencer may move: armed and no control write in this cycle
	logic quiet;
	assign quiet = armed_reg && !ctl_wr;

	// sitting in a state with a given select code and free to move
	sequence s_in(dsnx_seq_state_t st, logic [3:0] code);
		quiet && state_reg == st && ((st == SEQ_STATE1) ? scr1_reg[3:0] : scr2_reg[3:0]) == code;
	endsequence

	// a register request taken, its answer due on the next edge
	sequence s_taken(logic [5:0] idx);
		wb_req_in.cyc && wb_req_in.stb && !rsp_reg.ack && reg_hit(wb_req_in.adr, idx);
	endsequence

	// selection while in state1, with the code 7, code B and reserved-code checks in state2
	a_s1_code8_ch0: assert property (s_in(SEQ_STATE1, DSNX_SC_8) and (match_in[0]) // see [RULE_01]
			|=> state_reg == SEQ_STATE2)
		else $error("state1 code 8 channel 0 did not reach state2");
	a_s1_code10: assert property (s_in(SEQ_STATE1, DSNX_SC_A) and (match_in[3] && !match_in[1]) // see [RULE_02]
			|=> state_reg == SEQ_STATE3)
		else $error("state1 code A channel 3 did not reach state3");
	a_s1_codea_ch1: assert property (s_in(SEQ_STATE1, DSNX_SC_A) and (match_in[1]) // see [RULE_02]
			|=> state_reg == SEQ_STATE2)
		else $error("state1 code A channel 1 did not reach state2");
	a_s1_code12: assert property (s_in(SEQ_STATE1, DSNX_SC_C) and (match_in == 4'h8) // see [RULE_03]
			|=> $stable(state_reg))
		else $error("state1 code C channel 3 moved the sequencer");
	a_s1_codec_low: assert property (s_in(SEQ_STATE1, DSNX_SC_C) and (match_in[2:0] != 3'h0) // see [RULE_03]
			|=> state_reg == SEQ_STATE2)
		else $error("state1 code C low channel did not reach state2");
	a_s1_code7_ch1: assert property (s_in(SEQ_STATE1, DSNX_SC_7) and (match_in[1] && !match_in[0]) // see [RULE_04]
			|=> state_reg == SEQ_STATE3)
		else $error("state1 code 7 channel 1 did not reach state3");
	a_final_prio: assert property (s_in(SEQ_STATE2, DSNX_SC_7) and (match_in[0]) // see [RULE_04]
			|=> state_reg == SEQ_FINAL)
		else $error("code 7 channel 0 did not reach final");
	a_code9_ch2: assert property (s_in(SEQ_STATE1, DSNX_SC_9) and (match_in[2] && !match_in[0]) // see [RULE_05]
			|=> state_reg == SEQ_STATE3)
		else $error("code 9 channel 2 did not reach state3");
	a_code11_ch1: assert property (s_in(SEQ_STATE2, DSNX_SC_B) and (match_in[1]) // see [RULE_06]
			|=> state_reg == SEQ_FINAL)
		else $error("code B channel 1 did not reach final");
	a_reserved_s1: assert property (quiet && state_reg == SEQ_STATE1 && scr1_reg[3:0] >= DSNX_SC_D // see [RULE_07]
			|=> state_reg == SEQ_STATE1)
		else $error("reserved state1 code moved the sequencer");
	a_reserved_hold: assert property (quiet && state_reg == SEQ_STATE2 && scr2_reg[3:0] >= 4'hE // see [RULE_07]
			|=> state_reg == SEQ_STATE2)
		else $error("reserved code moved the sequencer");
	a_s1_any_final: assert property (s_in(SEQ_STATE1, DSNX_SC_2) and (match_in != 4'h0) // see [RULE_22]
			|=> state_reg == SEQ_FINAL)
		else $error("state1 code 2 any match did not reach final");

	// selection while in state2, then the hold in state3 and final
	a_s2_any_one: assert property (s_in(SEQ_STATE2, DSNX_SC_0) and (match_in != 4'h0) // see [RULE_08]
			|=> state_reg == SEQ_STATE1)
		else $error("state2 code 0 any match did not reach state1");
	a_s2_ch3_only: assert property (s_in(SEQ_STATE2, DSNX_SC_5) and (match_in[3] == 1'b0) // see [RULE_09]
			|=> state_reg == SEQ_STATE2)
		else $error("state2 code 5 moved without channel 3");
	a_s2_code4: assert property (s_in(SEQ_STATE2, DSNX_SC_4) and (match_in[3]) // see [RULE_09]
			|=> state_reg == SEQ_STATE3)
		else $error("state2 code 4 channel 3 did not reach state3");
	a_s2_code8: assert property (s_in(SEQ_STATE2, DSNX_SC_8) and (match_in[2] && !match_in[0]) // see [RULE_11]
			|=> state_reg == SEQ_STATE3)
		else $error("state2 code 8 channel 2 did not reach state3");
	a_s2_codea: assert property (s_in(SEQ_STATE2, DSNX_SC_A) and (match_in[1]) // see [RULE_12]
			|=> state_reg == SEQ_STATE1)
		else $error("state2 code A channel 1 did not reach state1");
	a_s2_code12: assert property (s_in(SEQ_STATE2, DSNX_SC_C) // see [RULE_13] see [RULE_16]
			and (match_in[3] && match_in[2]) |=> state_reg == SEQ_FINAL)
		else $error("state2 code C final did not take precedence");
	a_s2_code13: assert property (s_in(SEQ_STATE2, DSNX_SC_D) and (match_in == 4'h4) // see [RULE_14]
			|=> state_reg == SEQ_STATE2)
		else $error("state2 code D channel 2 moved the sequencer");
	a_low_chan: assert property (s_in(SEQ_STATE2, DSNX_SC_6) // see [RULE_15] see [RULE_10]
			and (match_in[0] && match_in[1]) |=> state_reg == SEQ_STATE1)
		else $error("lower channel did not win");
	a_end_hold: assert property (quiet && (state_reg == SEQ_STATE3 || state_reg == SEQ_FINAL) // see [RULE_23]
			|=> $stable(state_reg))
		else $error("state3 or final moved on a match");

	// register window and arming
	a_armed_lock: assert property (armed_reg && wr_take && reg_hit(wb_req_in.adr, DSNX_IDX_SCR) // see [RULE_18]
			|=> $stable(scr2_reg) && $stable(scr1_reg))
		else $error("select register changed while armed");
	a_view_read: assert property (s_taken(DSNX_IDX_SCR) and (view == DSNX_VIEW_S2) // see [RULE_17]
			|=> rsp_reg.ack && rsp_reg.dat[7:0] == scr2_reg)
		else $error("view 01 read did not return state2 register");
	a_flag_view: assert property (s_taken(DSNX_IDX_SCR) and (view == DSNX_VIEW_FLAGS) // see [RULE_21]
			|=> rsp_reg.ack && rsp_reg.dat[7:0] == {4'h0, $past(flags_reg)})
		else $error("view 11 read did not return match flags");
	a_disarm_idle: assert property (ctl_wr && !wb_req_in.dat[DSNX_CTL_ARM_BIT]
			|=> state_reg == SEQ_IDLE && !armed_reg)
		else $error("disarm did not return to idle");
	a_unarmed_idle: assert property (!armed_reg && !arm_evt
			|=> state_reg == SEQ_IDLE)
		else $error("sequencer moved while not armed");
	a_flags_clear: assert property (arm_evt
			|=> flags_reg == '0)
		else $error("arming did not clear match flags");
	a_ack_pulse: assert property (rsp_reg.ack |=> !rsp_reg.ack)
		else $error("ack held for more than one cycle");
endmodule // dsnx_sequencer

/* sim/dsnx_match_model.sv */
// comparator match channels seen from the sequencer
// assumes raw hits arrive on the system clock from the bench
`timescale 1ns/10ps
module dsnx_match_model (
	input wire logic [3:0] raw_hit_in,
	input wire logic [3:0] cmp_enable_in,
	output logic [3:0] match_out
);
	// a disabled comparator never reaches the sequencer
	assign match_out = raw_hit_in & cmp_enable_in;
endmodule // dsnx_match_model

/* sim/dsnx_sequencer_tb.sv */
// self-checking bench for the sequencer next-state block
// assumes a wishbone slave answering one cycle after the request is taken
`timescale 1ns/10ps
module dsnx_sequencer_tb;
	import dsnx_pkg::*;
	logic clk;
	logic rst;
	dsnx_wb_req_t req;
	dsnx_wb_rsp_t rsp;
	logic [3:0] raw;
	logic [3:0] en;
	logic [3:0] match;
	dsnx_seq_state_t st;
	logic armed;
	logic [3:0] flags;
	int bad_count;
	int checks;
	localparam dsnx_seq_state_t S1 = SEQ_STATE1;
	localparam dsnx_seq_state_t S2 = SEQ_STATE2;
	localparam dsnx_seq_state_t S3 = SEQ_STATE3;
	localparam dsnx_seq_state_t F = SEQ_FINAL;

	dsnx_match_model i_dsnx_match_model (.raw_hit_in(raw), .cmp_enable_in(en), .match_out(match));
	dsnx_sequencer i_dsnx_sequencer (.core_clk_in(clk), .sys_rst_in(rst), .wb_req_in(req), .wb_rsp_out(rsp),
		.match_in(match), .seq_state_out(st), .armed_out(armed), .match_flags_out(flags));

	initial begin
		clk = 1'b0;
		forever #2.5 clk = ~clk;
	end

	task summarize;
		begin
			$display("checks %0d bad_count %0d", checks, bad_count);
			if (bad_count == 0 && checks > 0) begin
				$display("No errors found");
			end else begin
				$display("Errors were found");
			end
			$finish;
		end
	endtask

	task chk_val(input string name, input logic [31:0] exp, input logic [31:0] got);
		begin
			checks++;
			if (got !== exp) begin
				bad_count++;
				$display("BAD %s expected %h seen %h", name, exp, got);
			end
		end
	endtask

	task chk_st(input string name, input dsnx_seq_state_t exp, input dsnx_seq_state_t got);
		begin
			checks++;
			if (got !== exp) begin
				bad_count++;
				$display("BAD %s expected %0d seen %0d", name, exp, got);
			end
		end
	endtask

	task wb(input logic we, input logic [7:0] a, input logic [31:0] d, output logic [31:0] q);
		int n;
		begin
			@(posedge clk);
			req <= '{cyc: 1'b1, stb: 1'b1, we: we, adr: a, sel: 4'hF, dat: d};
			n = 0;
			do begin
				@(posedge clk);
				n++;
			end while (rsp.ack !== 1'b1 && n < 50);
			if (n >= 50) chk_val("ack", 32'h1, 32'h0);
			q = rsp.dat;
			req <= '0;
		end
	endtask

	task pulse(input logic [3:0] m);
		begin
			@(posedge clk);
			raw <= m;
			@(posedge clk);
			raw <= 4'h0;
			#1;
		end
	endtask

	task run(input bit s2, input logic [3:0] code, input logic [3:0] m, input dsnx_seq_state_t exp);
		logic [31:0] q;
		begin
			wb(1'b1, 8'h98, 32'h00, q);
			wb(1'b1, 8'h9C, s2 ? 32'h0 : {28'h0, code}, q);
			wb(1'b1, 8'h98, 32'h01, q);
			wb(1'b1, 8'h9C, s2 ? {28'h0, code} : 32'h0, q);
			wb(1'b1, 8'h98, 32'h80, q);
			if (s2) begin
				pulse(4'h1);
				chk_st("enter state2", S2, st);
			end
			pulse(m);
			chk_st("next state", exp, st);
		end
	endtask

	task regs;
		logic [31:0] q;
		begin
			wb(1'b0, 8'h9C, 32'h0, q);
			chk_val("select reset", 32'h0, q);
			wb(1'b1, 8'h98, 32'h01, q);
			wb(1'b1, 8'h9C, 32'hFF, q);
			wb(1'b0, 8'h9C, 32'h0, q);
			chk_val("state2 select width", 32'h0F, q);
			wb(1'b1, 8'h98, 32'h00, q);
			wb(1'b1, 8'h9C, 32'h05, q);
			wb(1'b1, 8'h98, 32'h01, q);
			wb(1'b0, 8'h9C, 32'h0, q);
			chk_val("state2 view", 32'h0F, q);
			wb(1'b1, 8'h98, 32'h02, q);
			wb(1'b1, 8'h9C, 32'h0A, q);
			wb(1'b0, 8'h9C, 32'h0, q);
			chk_val("state3 view", 32'h0A, q);
			wb(1'b1, 8'h98, 32'h00, q);
			wb(1'b0, 8'h9C, 32'h0, q);
			chk_val("state1 view", 32'h05, q);
			wb(1'b1, 8'h98, 32'h81, q);
			wb(1'b1, 8'h9C, 32'h03, q);
			wb(1'b0, 8'h9C, 32'h0, q);
			chk_val("armed write", 32'h0F, q);
			chk_val("armed", 32'h1, {31'h0, armed});
			wb(1'b1, 8'h98, 32'h83, q);
			pulse(4'h5);
			wb(1'b0, 8'h9C, 32'h0, q);
			chk_val("flag view", 32'h05, q);
			chk_val("flags", 32'h5, {28'h0, flags});
			wb(1'b0, 8'h98, 32'h0, q);
			chk_val("control view", 32'h83, q);
			wb(1'b0, 8'h10, 32'h0, q);
			chk_val("unmapped", 32'h0, q);
		end
	endtask

	// a disabled comparator must not reach the sequencer
	task gated;
		begin
			@(posedge clk);
			en <= 4'hE;
			run(0, 4'h0, 4'h1, S1);
			run(0, 4'h0, 4'h3, S2);
			@(posedge clk);
			en <= 4'hF;
		end
	endtask

	initial begin
		#100000;
		bad_count++;
		summarize();
	end

	initial begin
		rst = 1'b1;
		req = '0;
		raw = 4'h0;
		en = 4'hF;
		bad_count = 0;
		checks = 0;
		repeat (6) @(posedge clk);
		rst <= 1'b0;
		regs();
		run(0, 4'h0, 4'h8, S2);
		run(0, 4'h1, 4'h4, S3);
		run(0, 4'h2, 4'h2, F);
		run(0, 4'h3, 4'h4, S2);
		run(0, 4'h3, 4'h8, S1);
		run(0, 4'h4, 4'h4, S3);
		run(0, 4'h5, 4'h4, F);
		run(0, 4'h6, 4'h1, S2);
		run(0, 4'h6, 4'h2, S3);
		run(0, 4'h8, 4'h1, S2);
		run(0, 4'h8, 4'h4, S3);
		run(0, 4'h8, 4'hA, S1);
		run(0, 4'hA, 4'h2, S2);
		run(0, 4'hA, 4'h8, S3);
		run(0, 4'hA, 4'h5, S1);
		run(0, 4'hC, 4'h4, S2);
		run(0, 4'hC, 4'h8, S1);
		run(0, 4'h7, 4'h2, S3);
		run(1, 4'h7, 4'h1, F);
		run(1, 4'h7, 4'hC, S2);
		run(0, 4'h9, 4'h4, S3);
		run(1, 4'h9, 4'h1, F);
		run(1, 4'hB, 4'h8, S3);
		run(0, 4'hB, 4'h2, F);
		run(0, 4'hD, 4'hF, S1);
		run(0, 4'hF, 4'hF, S1);
		run(1, 4'hE, 4'hF, S2);
		run(1, 4'hF, 4'hF, S2);
		run(1, 4'h0, 4'h8, S1);
		run(1, 4'h1, 4'h2, S3);
		run(1, 4'h2, 4'h4, F);
		run(1, 4'h3, 4'h8, S1);
		run(1, 4'h4, 4'h8, S3);
		run(1, 4'h5, 4'h8, F);
		run(1, 4'h5, 4'h7, S2);
		run(1, 4'h6, 4'h1, S1);
		run(1, 4'h6, 4'h2, S3);
		run(1, 4'h8, 4'h1, S1);
		run(1, 4'h8, 4'h4, S3);
		run(1, 4'hA, 4'h2, S1);
		run(1, 4'hA, 4'h8, S3);
		run(1, 4'hC, 4'h4, S1);
		run(1, 4'hC, 4'h8, F);
		run(1, 4'hD, 4'hB, F);
		run(1, 4'hD, 4'h4, S2);
		run(0, 4'h8, 4'h5, S2);
		run(1, 4'h6, 4'h3, S1);
		run(1, 4'hB, 4'hA, F);
		run(1, 4'hC, 4'hC, F);
		run(0, 4'h9, 4'h5, F);
		gated();
		summarize();
	end
endmodule // dsnx_sequencer_tb
